// [core/sapt_quad.sv]
// Purpose : shared constants of the absolute position transmitter and the
//           incremental quadrature track generator
// Assumes : 100 MHz core clock, phase taken from the direction-corrected position
// Notes   : package and leaf module share this file so the core stays two files

// ---------------------------------------------------------------------------
// shared constants
// ---------------------------------------------------------------------------
package sapt_pkg;
  // core clock rate
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned CLK_KHZ      = CLK_HZ / 1000;
  localparam int unsigned CLK_MHZ      = CLK_HZ / 1_000_000;
  // monoflop time in microseconds and its cycle count
  localparam int unsigned TM_US        = 20;
  localparam int unsigned TM_CYC       = TM_US * CLK_MHZ;
  // power-up availability delay in milliseconds
  localparam int unsigned PWRUP_MS     = 450;
  localparam int unsigned PWRUP_CYC    = PWRUP_MS * CLK_KHZ;
  // both-button hold time in milliseconds
  localparam int unsigned BTN_MS       = 2000;
  localparam int unsigned BTN_CYC      = BTN_MS * CLK_KHZ;
  // electrical zero-set low time in milliseconds
  localparam int unsigned ZS_MS        = 1100;
  localparam int unsigned ZS_CYC       = ZS_MS * CLK_KHZ;
  // resolution defaults and limits
  localparam int unsigned ST_BITS_DEF  = 13;
  localparam int unsigned MT_BITS_DEF  = 12;
  localparam int unsigned FIELD_MAX    = 16;
  localparam int unsigned WORD_MAX     = 32;
  // incremental pulses per revolution as a power of two
  localparam int unsigned PPR_LOG2_DEF = 10;
  localparam int unsigned PPR_LOG2_MIN = 10;
  localparam int unsigned PPR_LOG2_MAX = 12;
  // register byte offsets
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h4;
  localparam logic [3:0]  REG_POS      = 4'h8;
  localparam logic [3:0]  REG_ZERO     = 4'hC;
  // register field positions
  localparam int unsigned CTRL_GRAY    = 0;
  localparam int unsigned CTRL_INCR    = 1;
  localparam int unsigned STAT_READY   = 0;
  localparam int unsigned STAT_BUSY    = 1;
  // register reset values
  localparam logic        CTRL_GRAY_RST = 1'h1;
  localparam logic        CTRL_INCR_RST = 1'h1;
  // synchroniser lane positions
  localparam int unsigned SY_CLK       = 0;
  localparam int unsigned SY_DIR       = 1;
  localparam int unsigned SY_ZS        = 2;
  localparam int unsigned SY_BA        = 3;
  localparam int unsigned SY_BB        = 4;
  localparam int unsigned SY_W         = 5;
endpackage : sapt_pkg

// ---------------------------------------------------------------------------
// quadrature track generator
// ---------------------------------------------------------------------------
module sapt_quad (
  input  wire logic       i_clk,    // core clock
  input  wire logic       i_reset,  // synchronous reset, high
  input  wire logic       i_ce,     // clock enable
  input  wire logic       i_en,     // tracks enabled
  input  wire logic [1:0] i_phase,  // quarter-period index
  output logic            o_a,      // track a
  output logic            o_b,      // track b
  output logic            o_a_n,    // track a complement
  output logic            o_b_n     // track b complement
);
  import sapt_pkg::*;

  // all state of the generator
  typedef struct packed {
    logic a;
    logic b;
    logic a_n;
    logic b_n;
  } sapt_quad_st_t;

  sapt_quad_st_t st_reg;   // registered state
  sapt_quad_st_t st_next;  // next state

  // gray sequence over the phase: b leads a one way, lags the other
  always_comb begin
    st_next     = st_reg;
    st_next.a   = i_en & i_phase[1];                  // [R17]
    st_next.b   = i_en & (i_phase[1] ^ i_phase[0]);   // [R20]
    st_next.a_n = ~st_next.a;                         // [R17]
    st_next.b_n = ~st_next.b;
  end

  // register, frozen while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      // tracks low, complements high while in reset
      st_reg <= '{a: 1'b0, b: 1'b0, a_n: 1'b1, b_n: 1'b1};
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_a   = st_reg.a;
  assign o_b   = st_reg.b;
  assign o_a_n = st_reg.a_n;
  assign o_b_n = st_reg.b_n;
endmodule : sapt_quad

// [core/sapt_top.sv]
// Purpose : encoder-side serial position transmitter with zero set, code and
//           direction selection, incremental tracks and an Avalon-MM slave
// Assumes : raw position counts up on clockwise rotation, same clock domain
// Notes   : the serial clock is oversampled by the core clock
//
// Notes on behaviour
// R1: idle: master clock high, data held high
// R2: first falling clock edge captures position
// R3: first rising edge drives the msb
// R4: each later rising edge drives next bit
// R5: after lsb, data low until monoflop ends
// R6: master waits for data high or pause
// R7: monoflop starts at last falling edge
// R8: master clock period below monoflop time
// R9: word has singleturn plus multiturn bits
// R10: unbroken clocking resends the same word
// R11: late pulse n+1 gives fresh position
// R12: master limits clock rate by line length
// R13: both buttons held 2 s sets zero
// R14: gray or binary output code
// R15: direction input high: clockwise counts down
// R16: position invalid up to 450 ms
// R17: incremental a, b and complements
// R18: zero-set low 1.1 s sets zero
// R19: clock stuck high mid-word aborts to idle
// R20: b leads or lags a by quarter

module sapt_top
  import sapt_pkg::*;
#(
  parameter int unsigned ST_BITS   = sapt_pkg::ST_BITS_DEF,   // singleturn bits
  parameter int unsigned MT_BITS   = sapt_pkg::MT_BITS_DEF,   // multiturn bits
  parameter int unsigned PPR_LOG2  = sapt_pkg::PPR_LOG2_DEF,  // log2 pulses per turn
  parameter int unsigned TM_CYC_P  = sapt_pkg::TM_CYC,        // monoflop cycles
  parameter int unsigned PWRUP_CYC_P = sapt_pkg::PWRUP_CYC,   // availability delay
  parameter int unsigned BTN_CYC_P = sapt_pkg::BTN_CYC,       // button hold
  parameter int unsigned ZS_CYC_P  = sapt_pkg::ZS_CYC         // zero-set hold
) (
  input  wire logic                       I_CORE_CLK,        // core clock
  input  wire logic                       I_RESET,           // synchronous reset
  input  wire logic                       I_CLK_EN,          // clock enable
  input  wire logic [ST_BITS+MT_BITS-1:0] I_RAW_POS,         // raw position
  input  wire logic                       I_SSI_CLK,         // serial clock pin
  input  wire logic                       I_DIR_SEL,         // direction select pin
  input  wire logic                       I_ZERO_SET_N,      // zero-set pin, low
  input  wire logic                       I_ZERO_BTN_A,      // button a pressed
  input  wire logic                       I_ZERO_BTN_B,      // button b pressed
  input  wire logic [3:0]                 I_AVS_ADDRESS,     // byte address
  input  wire logic                       I_AVS_READ,        // read request
  input  wire logic                       I_AVS_WRITE,       // write request
  input  wire logic [31:0]                I_AVS_WRITEDATA,   // write data
  input  wire logic [3:0]                 I_AVS_BYTEENABLE,  // byte enables
  output logic      [31:0]                O_AVS_READDATA,    // read data
  output logic                            O_AVS_WAITREQUEST, // stall
  output logic                            O_SSI_DATA,        // serial data
  output logic                            O_INC_A,           // track a
  output logic                            O_INC_B,           // track b
  output logic                            O_INC_A_N,         // track a complement
  output logic                            O_INC_B_N          // track b complement
);
  import sapt_pkg::*;

  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  localparam int unsigned N = ST_BITS + MT_BITS;  // bits per word [R9]
  if (ST_BITS == 0 || ST_BITS > FIELD_MAX || MT_BITS > FIELD_MAX || N > WORD_MAX)
    $error("resolution out of range");
  if (PPR_LOG2 < PPR_LOG2_MIN || PPR_LOG2 > PPR_LOG2_MAX || ST_BITS < PPR_LOG2 + 2)
    $error("pulse count not servable");
  if (TM_CYC_P < 2 || PWRUP_CYC_P < 1 || BTN_CYC_P < 1 || ZS_CYC_P < 1)
    $error("timing count too small");

  localparam logic [5:0]   N_CNT = 6'(N);        // bit count target
  localparam logic [N-1:0] ONE_N = N'(1);        // one at word width
  localparam int unsigned  PH_LO = ST_BITS - PPR_LOG2 - 2;  // quarter bit

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef enum {S_IDLE, S_SHIFT, S_TRAIL} sapt_ssi_t;

  typedef struct packed {
    logic [SY_W-1:0] sync1;    // first synchroniser stage
    logic [SY_W-1:0] sync2;    // second synchroniser stage
    logic            clk_d;    // previous serial clock level
    logic            zs_d;     // previous zero-set level
    sapt_ssi_t       ssi;      // transfer phase
    logic [5:0]      cnt;      // bits sent in this word
    logic [31:0]     timer;    // monoflop timer
    logic [N-1:0]    shreg;    // output shift register
    logic [N-1:0]    word;     // captured word for repetition
    logic            data;     // serial data level
    logic [N-1:0]    zero;     // zero-point offset
    logic [31:0]     pwr_cnt;  // availability counter
    logic            ready;    // position valid
    logic [31:0]     zs_cnt;   // zero-set low time
    logic            zs_arm;   // falling edge seen
    logic [31:0]     btn_cnt;  // both-button hold time
    logic            gray;     // gray code selected
    logic            incr;     // incremental tracks enabled
    logic [31:0]     rdata;    // bus read data
    logic            ack;      // bus answer cycle
  } sapt_st_t;

  sapt_st_t     st_reg;    // registered state
  sapt_st_t     st_next;   // next state
  logic [N-1:0] pos_dir;   // direction-corrected position
  logic [N-1:0] rel;       // position relative to zero
  logic [N-1:0] cur_word;  // word offered at capture
  logic         clk_s;     // synchronised serial clock
  logic         fall;      // serial clock falling edge
  logic         rise;      // serial clock rising edge
  logic         bus_req;   // bus request present

  // ---------------------------------------------------------------------------
  // position path
  // ---------------------------------------------------------------------------
  // direction, zero offset and code selection
  always_comb begin
    pos_dir = st_reg.sync2[SY_DIR] ? (~I_RAW_POS + ONE_N) : I_RAW_POS;  // [R15]
    rel     = pos_dir - st_reg.zero;
    if (!st_reg.ready) begin
      cur_word = '0;                                      // [R16]
    end else if (st_reg.gray) begin
      cur_word = rel ^ (rel >> 1);                        // [R14]
    end else begin
      cur_word = rel;                                     // [R14]
    end
  end

  assign clk_s   = st_reg.sync2[SY_CLK];
  assign fall    = st_reg.clk_d & ~clk_s;
  assign rise    = ~st_reg.clk_d & clk_s;
  assign bus_req = I_AVS_READ | I_AVS_WRITE;

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    // pin synchronisers
    st_next.sync1 = {I_ZERO_BTN_B, I_ZERO_BTN_A, I_ZERO_SET_N, I_DIR_SEL, I_SSI_CLK};
    st_next.sync2 = st_reg.sync1;
    st_next.clk_d = clk_s;
    st_next.zs_d  = st_reg.sync2[SY_ZS];

    // availability delay after reset
    if (!st_reg.ready) begin
      if (st_reg.pwr_cnt >= PWRUP_CYC_P - 1) begin
        st_next.ready = 1'b1;                             // [R16]
      end else begin
        st_next.pwr_cnt = st_reg.pwr_cnt + 32'h1;
      end
    end

    // monoflop timer saturates at its limit
    if (st_reg.timer < TM_CYC_P) begin
      st_next.timer = st_reg.timer + 32'h1;
    end

    // serial transfer
    unique case (st_reg.ssi)
      S_IDLE: begin
        st_next.data = 1'b1;                              // [R1]
        if (fall) begin
          st_next.shreg = cur_word;                       // [R2] [R11]
          st_next.word  = cur_word;
          st_next.cnt   = 6'h0;
          st_next.timer = 32'h0;
          st_next.ssi   = S_SHIFT;
        end
      end
      S_SHIFT: begin
        if (rise && st_reg.cnt < N_CNT) begin
          st_next.data  = st_reg.shreg[N-1];              // [R3] [R4]
          st_next.shreg = st_reg.shreg << 1;
          st_next.cnt   = st_reg.cnt + 6'h1;
          st_next.timer = 32'h0;
        end else if (fall) begin
          st_next.timer = 32'h0;                          // [R7]
          if (st_reg.cnt == N_CNT) begin
            st_next.ssi  = S_TRAIL;                       // [R9]
            st_next.data = 1'b0;                          // [R5]
          end
        end else if (clk_s && st_reg.timer >= TM_CYC_P) begin
          st_next.ssi  = S_IDLE;                          // [R19]
          st_next.data = 1'b1;
        end
      end
      S_TRAIL: begin
        if (rise) begin
          st_next.data  = st_reg.word[N-1];               // [R10]
          st_next.shreg = st_reg.word << 1;
          st_next.cnt   = 6'h1;
          st_next.timer = 32'h0;
          st_next.ssi   = S_SHIFT;
        end else if (st_reg.timer >= TM_CYC_P) begin
          st_next.ssi  = S_IDLE;                          // [R5] [R11]
          st_next.data = 1'b1;
        end
      end
    endcase

    // electrical zero set: falling edge, then held low
    if (st_reg.sync2[SY_ZS]) begin
      st_next.zs_arm = 1'b0;
      st_next.zs_cnt = 32'h0;
    end else if (st_reg.zs_d) begin
      st_next.zs_arm = 1'b1;                              // [R18]
      st_next.zs_cnt = 32'h1;
    end else if (st_reg.zs_arm && st_reg.zs_cnt < ZS_CYC_P) begin
      st_next.zs_cnt = st_reg.zs_cnt + 32'h1;
      if (st_reg.zs_cnt == ZS_CYC_P - 1) begin
        st_next.zero = pos_dir;                           // [R18]
      end
    end

    // push buttons: both held, zero taken on release
    if (st_reg.sync2[SY_BA] && st_reg.sync2[SY_BB]) begin
      if (st_reg.btn_cnt < BTN_CYC_P) begin
        st_next.btn_cnt = st_reg.btn_cnt + 32'h1;
      end
    end else begin
      if (st_reg.btn_cnt >= BTN_CYC_P) begin
        st_next.zero = pos_dir;                           // [R13]
      end
      st_next.btn_cnt = 32'h0;
    end

    // bus slave: one wait state, then answer
    st_next.ack = bus_req & ~st_reg.ack;
    if (I_AVS_READ && !st_reg.ack) begin
      unique case (I_AVS_ADDRESS)
        REG_CTRL:   st_next.rdata = {30'h0, st_reg.incr, st_reg.gray};
        REG_STATUS: st_next.rdata = {30'h0, st_reg.ssi != S_IDLE, st_reg.ready};
        REG_POS:    st_next.rdata = 32'(cur_word);
        REG_ZERO:   st_next.rdata = 32'(st_reg.zero);
        default:    st_next.rdata = 32'h0;
      endcase
    end
    if (I_AVS_WRITE && st_reg.ack && I_AVS_ADDRESS == REG_CTRL && I_AVS_BYTEENABLE[0]) begin
      st_next.gray = I_AVS_WRITEDATA[CTRL_GRAY];
      st_next.incr = I_AVS_WRITEDATA[CTRL_INCR];
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      st_reg       <= '0;
      // idle pin levels: clock, direction and zero-set high, buttons released
      st_reg.sync1 <= 5'h07;
      st_reg.sync2 <= 5'h07;
      st_reg.clk_d <= 1'b1;
      st_reg.zs_d  <= 1'b1;
      st_reg.data  <= 1'b1;
      st_reg.gray  <= CTRL_GRAY_RST;
      st_reg.incr  <= CTRL_INCR_RST;
    end else if (I_CLK_EN) begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign O_SSI_DATA        = st_reg.data;
  assign O_AVS_READDATA    = st_reg.rdata;
  assign O_AVS_WAITREQUEST = bus_req & ~st_reg.ack;

  // incremental tracks from the direction-corrected singleturn part
  sapt_quad u_quad (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .i_ce    (I_CLK_EN),
    .i_en    (st_reg.incr),
    .i_phase (pos_dir[PH_LO +: 2]),  // [R17] [R20]
    .o_a     (O_INC_A),
    .o_b     (O_INC_B),
    .o_a_n   (O_INC_A_N),
    .o_b_n   (O_INC_B_N)
  );

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  a_idle_data_high: assert property (st_reg.ssi == S_IDLE |-> O_SSI_DATA) // [R1]
    else $error("data not high while idle");
  a_capture_fall: assert property ( // [R2]
    (I_CLK_EN && st_reg.ssi == S_IDLE && fall) |=>
      (st_reg.ssi == S_SHIFT && st_reg.word == $past(cur_word) && st_reg.cnt == 6'h0))
    else $error("word not captured on first falling edge");
  a_msb_first: assert property ( // [R3]
    (I_CLK_EN && st_reg.ssi == S_SHIFT && rise && st_reg.cnt == 6'h0) |=>
      (O_SSI_DATA == st_reg.word[N-1]))
    else $error("msb not driven on first rising edge");
  a_next_bit: assert property ( // [R4]
    (I_CLK_EN && st_reg.ssi == S_SHIFT && rise && st_reg.cnt < N_CNT) |=>
      (st_reg.cnt == $past(st_reg.cnt) + 6'h1 && O_SSI_DATA == $past(st_reg.shreg[N-1])))
    else $error("bit not advanced on rising edge");
  a_trail_low: assert property (st_reg.ssi == S_TRAIL |-> !O_SSI_DATA) // [R5]
    else $error("data not low after lsb");
  a_mono_start: assert property ( // [R7]
    (I_CLK_EN && st_reg.ssi == S_SHIFT && fall && st_reg.cnt == N_CNT) |=>
      (st_reg.ssi == S_TRAIL && st_reg.timer == 32'h0))
    else $error("monoflop not started at last falling edge");
  a_word_width: assert property (st_reg.cnt <= N_CNT) // [R9]
    else $error("bit count beyond word width");
  a_ring_same: assert property ( // [R10]
    (I_CLK_EN && st_reg.ssi == S_TRAIL && rise) |=>
      (st_reg.ssi == S_SHIFT && st_reg.word == $past(st_reg.word)
       && O_SSI_DATA == st_reg.word[N-1]))
    else $error("repetition did not resend word");
  a_fresh_late: assert property ( // [R11]
    (I_CLK_EN && st_reg.ssi == S_TRAIL && !rise && st_reg.timer >= TM_CYC_P) |=>
      (st_reg.ssi == S_IDLE && O_SSI_DATA))
    else $error("no return to idle after monoflop");
  a_gray_code: assert property ((st_reg.ready && st_reg.gray) |-> // [R14]
    (cur_word == (rel ^ (rel >> 1))))
    else $error("gray code wrong");
  a_not_ready: assert property (!st_reg.ready |-> cur_word == '0) // [R16]
    else $error("position offered before ready");
  a_stuck_abort: assert property ( // [R19]
    (I_CLK_EN && st_reg.ssi == S_SHIFT && clk_s && !rise
     && st_reg.timer >= TM_CYC_P) |=> (st_reg.ssi == S_IDLE && O_SSI_DATA))
    else $error("stuck clock not aborted");

  c_full_word: cover property (st_reg.ssi == S_SHIFT ##1 st_reg.ssi == S_TRAIL);
  c_ring_slide: cover property (st_reg.ssi == S_TRAIL && rise && I_CLK_EN);
  c_abort: cover property (st_reg.ssi == S_SHIFT ##1 st_reg.ssi == S_IDLE);
  c_zero_set: cover property (I_CLK_EN && st_reg.zero != st_next.zero);
endmodule : sapt_top

// [verif/sapt_ssi_master.sv]
// Purpose : serial clock master model that reads position words
// Assumes : 125 ns link period, bits sampled late in the clock high phase
// Notes   : the link clock rests high between frames
// ---------------------------------------------------------------------------
// serial clock master
// ---------------------------------------------------------------------------
module sapt_ssi_master #(
  parameter int N     = 25,  // bits per word
  parameter int TM_NS = 500  // monoflop time in ns
) (
  output logic      o_clk,  // serial clock to the encoder
  input  wire logic i_data  // serial data from the encoder
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam real H = 62.5;  // half period, well below the monoflop time
  // no cable in the bench, so line-length rate caps are the system's to
  // clock rests high while idle
  initial o_clk = 1'b1;
  // burst of reps words without a pause; first and last word, data after lsb
  task automatic xfer(input int reps, output logic [31:0] w1, output logic [31:0] w2,
                      output logic lo, output logic hi);
    w2 = 32'h0;
    for (int i = 0; i < reps * N; i++) begin
      o_clk = 1'b0;
      #H;
      o_clk = 1'b1;
      #(H - 2.0);
      w2 = {w2[30:0], i_data};  // msb arrives first
      if (i == N - 1) w1 = w2;
      #2.0;
    end
    o_clk = 1'b0;  // last falling edge
    #(TM_NS - 100);
    lo = i_data;
    #200;
    hi = i_data;
    o_clk = 1'b1;  // back high a fixed 100 ns after the monoflop time
    #H;
  endtask : xfer
  // a few pulses, then the clock is left high
  task automatic stub(input int k);
    repeat (k) begin
      o_clk = 1'b0;
      #H;
      o_clk = 1'b1;
      #H;
    end
  endtask : stub
endmodule : sapt_ssi_master

// [verif/sapt_tb_top.sv]
// Purpose : self-checking bench for the serial position transmitter
// Assumes : shortened monoflop, power-up, button and zero-set counts
// Notes   : expected words come from raw position, direction, zero and code
// ---------------------------------------------------------------------------
// bench top
// ---------------------------------------------------------------------------
module sapt_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sapt_pkg::*;
  localparam int TM = 50;  // monoflop cycles
  logic        clk = 1'b0, rst = 1'b1, dir = 1'b0, zs_n = 1'b1, ba = 1'b0, bb = 1'b0;
  logic        rd = 1'b0, wr = 1'b0, wq, sclk, sdata, ta, tb, tan, tbn, g, lo, hi;
  logic [24:0] raw = 25'h0, z = 25'h0;
  logic [3:0]  adr = 4'h0;
  logic        ce = 1'b1;  // clock enable
  logic [3:0]  be = 4'hF;  // byte enables
  logic [31:0] wd = 32'h0, rdata, q, w1, w2;
  int          error_cnt = 0, n_tests = 0;
  sapt_top #(.TM_CYC_P(TM), .PWRUP_CYC_P(10), .BTN_CYC_P(20), .ZS_CYC_P(20)) u_dut (
    .I_CORE_CLK(clk), .I_RESET(rst), .I_CLK_EN(ce), .I_RAW_POS(raw), .I_SSI_CLK(sclk),
    .I_DIR_SEL(dir), .I_ZERO_SET_N(zs_n), .I_ZERO_BTN_A(ba), .I_ZERO_BTN_B(bb),
    .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
    .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wq),
    .O_SSI_DATA(sdata), .O_INC_A(ta), .O_INC_B(tb), .O_INC_A_N(tan), .O_INC_B_N(tbn));
  sapt_ssi_master #(.TM_NS(TM * 10)) u_mst (.o_clk(sclk), .i_data(sdata));
  // core clock, 100 MHz
  initial forever #5 clk = ~clk;
  // direction-corrected position
  function automatic logic [24:0] pd(logic [24:0] r, logic d);
    return d ? 25'(-r) : r;
  endfunction : pd
  // expected word in gray or binary
  function automatic logic [24:0] ew(logic [24:0] r, logic d, logic [24:0] zo, logic c);
    logic [24:0] p;
    p = pd(r, d) - zo;
    return c ? (p ^ (p >> 1)) : p;
  endfunction : ew
  // expected tracks a, b and complements
  function automatic logic [3:0] tq(logic [24:0] r, logic d);
    logic [1:0] ph;
    ph = pd(r, d)[2:1];
    return {ph[1], ph[1] ^ ph[0], ~ph[1], ~(ph[1] ^ ph[0])};
  endfunction : tq
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  // one bus transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      t++;
    end while (wq !== 1'b0 && t < 100);
    chk(t < 100, "bus stall");
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // one serial burst and its checks
  task automatic ssi(input int reps, input logic [24:0] e1, input logic [24:0] e2);
    u_mst.xfer(reps, w1, w2, lo, hi);
    chk(w1[24:0] === e1, "first word");
    chk(w2[24:0] === e2, "last word");
    chk(lo === 1'b0, "data not low after lsb");
    chk(hi === 1'b1, "data not high after monoflop");
  endtask : ssi
  task automatic report_and_stop;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  // watchdog
  initial begin
    #500_000;
    error_cnt++;
    report_and_stop();
  end
  // main sequence
  initial begin
    void'($urandom(96));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk(sdata === 1'b1, "idle data");
    chk({ta, tb, tan, tbn} === 4'h3, "track reset");
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[STAT_READY] === 1'b0, "ready early");
    repeat (12) @(posedge clk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[STAT_READY] === 1'b1, "not ready");
    // clock enable low freezes the bus answer
    ce <= 1'b0;
    fork
      bus(1'b0, REG_STATUS, 32'h0);
      begin
        repeat (20) @(posedge clk);
        chk(wq === 1'b1, "not frozen");
        ce <= 1'b1;
      end
    join
    chk(q[STAT_READY] === 1'b1, "read after freeze");
    // control write without byte lane 0 is ignored
    be <= 4'hE;
    bus(1'b1, REG_CTRL, 32'h0);
    be <= 4'hF;
    bus(1'b0, REG_CTRL, 32'h0);
    chk(q[1:0] === {CTRL_INCR_RST, CTRL_GRAY_RST}, "ctrl reset");
    bus(1'b0, 4'h6, 32'h0);
    chk(q === 32'h0, "unmapped read");
    for (int i = 0; i < 6; i++) begin
      g = 1'($urandom);
      bus(1'b1, REG_CTRL, {30'h0, 1'b1, g});
      raw <= (i == 0) ? 25'h0 : (i == 1) ? 25'h1FFFFFF : 25'($urandom);
      dir <= (i < 2) ? 1'(i) : 1'($urandom);
      repeat (8) @(posedge clk);
      chk({ta, tb, tan, tbn} === tq(raw, dir), "tracks");
      ssi(1, ew(raw, dir, z, g), ew(raw, dir, z, g));
      bus(1'b0, REG_POS, 32'h0);
      chk(q === {7'h0, ew(raw, dir, z, g)}, "pos reg");
    end
    // ring slide keeps the first word while the position moves
    fork
      ssi(2, ew(raw, dir, z, g), ew(raw, dir, z, g));
      begin
        repeat (100) @(posedge clk);
        raw <= raw + 25'h1234;
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[STAT_BUSY] === 1'b1, "busy during burst");
      end
    join
    ssi(1, ew(raw, dir, z, g), ew(raw, dir, z, g));
    // clock stuck high mid-word
    u_mst.stub(4);
    repeat (TM + 20) @(posedge clk);
    chk(sdata === 1'b1, "abort idle");
    ssi(1, ew(raw, dir, z, g), ew(raw, dir, z, g));
    // electrical zero set
    zs_n <= 1'b0;
    repeat (30) @(posedge clk);
    zs_n <= 1'b1;
    repeat (8) @(posedge clk);
    ssi(1, 25'h0, 25'h0);
    // both buttons held, then released
    raw <= 25'($urandom);
    ba <= 1'b1;
    bb <= 1'b1;
    repeat (30) @(posedge clk);
    ba <= 1'b0;
    bb <= 1'b0;
    repeat (8) @(posedge clk);
    ssi(1, 25'h0, 25'h0);
    bus(1'b0, REG_ZERO, 32'h0);
    chk(q[24:0] === pd(raw, dir), "zero reg");
    report_and_stop();
  end
endmodule : sapt_tb_top
